// ---- rtl/nvac_top.v ----
// Notes on behaviour
// - Space select resets zero, selects data EEPROM
// - Space select one: program memory, reads only
// - Triggers accept writes of one, ignore zero
// - Hardware clears trigger when operation finishes
// - Store starts only while store permit set
// - Store permit cleared at power-up
// - Reset during store sets surviving abort flag
// - Completed data write sets store-done flag
// - Unlock key port reads all zeros
// - Key port writes decoded only for stores
// - Low data register eight bits, reset zero
// - Low index register eight bits, reset zero
// - High data six bits, top two zero
// - High index five bits, top three zero
// - Byte write erases location before programming
// - Data EEPROM 256 bytes by low index
`timescale 1ns/1ns
`include "nvac_defs.vh"
module nvac_top (
	// Clock and power-on reset
	input wire clk_sys_i,
	input wire rst_b_i,
	// Warm resets, synchronous levels
	input wire external_reset_pin_i,
	input wire watchdog_expiry_i,
	// Special function register port
	input wire [2:0] sfr_sel_i,
	input wire sfr_we_i,
	input wire sfr_re_i,
	input wire [7:0] sfr_wdata_i,
	output wire [7:0] sfr_rdata_o,
	// Store-done flag in the second peripheral flag register
	input wire store_done_flag_clr_i,
	output wire store_done_irq_flag_o,
	// Array side
	output wire mem_space_o,
	output wire [12:0] mem_addr_o,
	output wire [7:0] mem_wdata_o,
	output wire mem_rd_req_o,
	output wire mem_erase_req_o,
	output wire mem_prog_req_o,
	input wire [13:0] mem_rdata_i,
	input wire mem_op_done_i
);

	localparam [3:0] S_IDLE = 4'h1;
	localparam [3:0] S_READ = 4'h2;
	localparam [3:0] S_ERASE = 4'h4;
	localparam [3:0] S_PROG = 4'h8;

	reg [3:0] state_q;
	reg [3:0] state_d;
	reg [1:0] rd_cnt_q;
	reg [1:0] rd_cnt_d;
	reg space_q;
	reg space_d;
	reg permit_q;
	reg permit_d;
	reg abort_q;
	reg abort_d;
	reg done_flag_q;
	reg done_flag_d;
	reg rd_req_q;
	reg erase_req_q;
	reg prog_req_q;
	reg [7:0] rdata_q;
	reg [7:0] rdata_d;

	wire soft_rst;
	wire idle;
	wire write_busy;
	wire ctl_we;
	wire key_we;
	wire armed;
	wire rd_start;
	wire wr_start;
	wire rd_finish;
	wire erase_finish;
	wire wr_finish;
	wire [7:0] data_lo;
	wire [`NVAC_DATA_HI_W-1:0] data_hi;
	wire [7:0] idx_lo;
	wire [`NVAC_IDX_HI_W-1:0] idx_hi;
	wire [7:0] ctl_rd;

	// Either warm reset abandons work in flight
	assign soft_rst = external_reset_pin_i || watchdog_expiry_i;
	assign idle = state_q[0];
	assign write_busy = state_q[2] || state_q[3];
	assign ctl_we = sfr_we_i && (sfr_sel_i == `NVAC_SEL_CTRL);
	assign key_we = sfr_we_i && (sfr_sel_i == `NVAC_SEL_KEY);

	assign rd_start = ctl_we && sfr_wdata_i[`NVAC_CTL_RD] && idle && !soft_rst;
	// unlock needed
	// The space bit of this same write is in force from the start edge,
	// so the written value, not the old one, must select data space
	assign wr_start = ctl_we && sfr_wdata_i[`NVAC_CTL_WR] && !sfr_wdata_i[`NVAC_CTL_RD] && idle &&
		!soft_rst && permit_q && !sfr_wdata_i[`NVAC_CTL_SPACE] && armed;

	// Capture on the last read cycle, while the array answer stands
	assign rd_finish = state_q[1] && (rd_cnt_q == `NVAC_RD_CYCLES - 2'h1);
	assign erase_finish = state_q[2] && mem_op_done_i;
	assign wr_finish = state_q[3] && mem_op_done_i;

	nvac_key_seq u_key (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.soft_rst_i(soft_rst),
		.key_we_i(key_we),
		.key_d_i(sfr_wdata_i),
		.consume_i(wr_start),
		.armed_o(armed)
	);

	// low data byte, loaded by any read
	nvac_reg #(.W(8), .RST(`NVAC_RST_BYTE)) u_data_lo (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.sw_we_i(sfr_we_i && (sfr_sel_i == `NVAC_SEL_DATA_LO)),
		.sw_d_i(sfr_wdata_i),
		.hw_we_i(rd_finish),
		.hw_d_i(mem_rdata_i[7:0]),
		.q_o(data_lo)
	);

	// upper six word bits, loaded by program reads only
	nvac_reg #(.W(`NVAC_DATA_HI_W), .RST(`NVAC_RST_DATA_HI)) u_data_hi (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.sw_we_i(sfr_we_i && (sfr_sel_i == `NVAC_SEL_DATA_HI)),
		.sw_d_i(sfr_wdata_i[`NVAC_DATA_HI_W-1:0]),
		.hw_we_i(rd_finish && space_q),
		.hw_d_i(mem_rdata_i[`NVAC_WORD_W-1:8]),
		.q_o(data_hi)
	);

	nvac_reg #(.W(8), .RST(`NVAC_RST_BYTE)) u_idx_lo (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.sw_we_i(sfr_we_i && (sfr_sel_i == `NVAC_SEL_IDX_LO)),
		.sw_d_i(sfr_wdata_i),
		.hw_we_i(1'b0),
		.hw_d_i(8'h00),
		.q_o(idx_lo)
	);

	nvac_reg #(.W(`NVAC_IDX_HI_W), .RST(`NVAC_RST_IDX_HI)) u_idx_hi (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.sw_we_i(sfr_we_i && (sfr_sel_i == `NVAC_SEL_IDX_HI)),
		.sw_d_i(sfr_wdata_i[`NVAC_IDX_HI_W-1:0]),
		.hw_we_i(1'b0),
		.hw_d_i(`NVAC_RST_IDX_HI),
		.q_o(idx_hi)
	);

	assign mem_addr_o = space_q ? {idx_hi, idx_lo} : {5'h00, idx_lo};
	assign mem_space_o = space_q;
	// Software must leave the low data byte alone until the store ends
	assign mem_wdata_o = data_lo;
	assign mem_rd_req_o = rd_req_q;
	assign mem_erase_req_o = erase_req_q;
	assign mem_prog_req_o = prog_req_q;
	assign store_done_irq_flag_o = done_flag_q;
	assign sfr_rdata_o = rdata_q;

	// trigger bits read back from the sequencer state
	assign ctl_rd = {space_q, 3'h0, abort_q, permit_q, write_busy, state_q[1]};

	always @* begin
		state_d = state_q;
		rd_cnt_d = rd_cnt_q;
		case (state_q)
			S_IDLE: begin
				rd_cnt_d = 2'h0;
				if (rd_start) begin
					state_d = S_READ;
				end else if (wr_start) begin
					state_d = S_ERASE;
				end
			end
			S_READ: begin
				rd_cnt_d = rd_cnt_q + 2'h1;
				// read trigger drops when data is captured
				if (rd_finish) begin
					state_d = S_IDLE;
				end
			end
			S_ERASE: begin
				if (erase_finish) begin
					state_d = S_PROG;
				end
			end
			S_PROG: begin
				if (wr_finish) begin
					state_d = S_IDLE;
				end
			end
			default: begin
				state_d = S_IDLE;
			end
		endcase
		// Warm reset abandons any operation
		if (soft_rst) begin
			state_d = S_IDLE;
		end
	end

	always @* begin
		space_d = space_q;
		permit_d = permit_q;
		if (soft_rst) begin
			space_d = 1'b0;
			permit_d = 1'b0;
		end else if (ctl_we) begin
			permit_d = sfr_wdata_i[`NVAC_CTL_PERMIT];
			// Space may not move under a running operation
			if (idle) begin
				space_d = sfr_wdata_i[`NVAC_CTL_SPACE];
			end
		end
	end

	always @* begin
		abort_d = abort_q;
		if (soft_rst && write_busy) begin
			abort_d = 1'b1;
		end else if (ctl_we) begin
			abort_d = sfr_wdata_i[`NVAC_CTL_ABORT];
		end
	end

	always @* begin
		done_flag_d = done_flag_q;
		if (wr_finish && !soft_rst) begin
			done_flag_d = 1'b1;
		end else if (store_done_flag_clr_i) begin
			done_flag_d = 1'b0;
		end
	end

	always @* begin
		rdata_d = rdata_q;
		if (sfr_re_i) begin
			case (sfr_sel_i)
				`NVAC_SEL_CTRL: rdata_d = ctl_rd;
				`NVAC_SEL_KEY: rdata_d = 8'h00;
				`NVAC_SEL_DATA_LO: rdata_d = data_lo;
				`NVAC_SEL_DATA_HI: rdata_d = {2'h0, data_hi};
				`NVAC_SEL_IDX_LO: rdata_d = idx_lo;
				`NVAC_SEL_IDX_HI: rdata_d = {3'h0, idx_hi};
				default: rdata_d = 8'h00;
			endcase
		end
	end

	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= S_IDLE;
			rd_cnt_q <= 2'h0;
			space_q <= 1'b0;
			permit_q <= 1'b0;
			abort_q <= 1'b0;
			done_flag_q <= 1'b0;
			rd_req_q <= 1'b0;
			erase_req_q <= 1'b0;
			prog_req_q <= 1'b0;
			rdata_q <= 8'h00;
		end else begin
			state_q <= state_d;
			rd_cnt_q <= rd_cnt_d;
			space_q <= space_d;
			permit_q <= permit_d;
			abort_q <= abort_d;
			done_flag_q <= done_flag_d;
			// Requests are single-cycle pulses towards the array
			rd_req_q <= rd_start;
			erase_req_q <= wr_start;
			prog_req_q <= erase_finish && !soft_rst;
			rdata_q <= rdata_d;
		end
	end

endmodule

// ---- common/nvac_defs.vh ----
`ifndef NVAC_DEFS_VH
`define NVAC_DEFS_VH

// Register select codes on the special-function-register port
`define NVAC_SEL_CTRL 3'h0
`define NVAC_SEL_KEY 3'h1
`define NVAC_SEL_DATA_LO 3'h2
`define NVAC_SEL_DATA_HI 3'h3
`define NVAC_SEL_IDX_LO 3'h4
`define NVAC_SEL_IDX_HI 3'h5

// Access control register fields
`define NVAC_CTL_RD 0
`define NVAC_CTL_WR 1
`define NVAC_CTL_PERMIT 2
`define NVAC_CTL_ABORT 3
`define NVAC_CTL_SPACE 7

// Field widths
`define NVAC_DATA_HI_W 6
`define NVAC_IDX_HI_W 5
`define NVAC_ADDR_W 13
`define NVAC_WORD_W 14

// Reset values
`define NVAC_RST_BYTE 8'h00
`define NVAC_RST_DATA_HI 6'h00
`define NVAC_RST_IDX_HI 5'h00

// Unlock key values written to the key port, in this order
`define NVAC_KEY_FIRST 8'h55
`define NVAC_KEY_SECOND 8'haa

// Array read latency in system clocks
`define NVAC_RD_CYCLES 2'h2

`endif

// ---- rtl/nvac_reg.v ----
`timescale 1ns/1ns
module nvac_reg #(
	parameter W = 8,
	parameter [W-1:0] RST = {W{1'b0}}
) (
	// Clock and reset
	input wire clk_sys_i,
	input wire rst_b_i,
	// Software side
	input wire sw_we_i,
	input wire [W-1:0] sw_d_i,
	// Hardware side, wins over software
	input wire hw_we_i,
	input wire [W-1:0] hw_d_i,
	// Value
	output wire [W-1:0] q_o
);

	reg [W-1:0] val_q;

	assign q_o = val_q;

	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			val_q <= RST;
		end else if (hw_we_i) begin
			val_q <= hw_d_i;
		end else if (sw_we_i) begin
			val_q <= sw_d_i;
		end
	end

endmodule

// ---- rtl/nvac_key_seq.v ----
`timescale 1ns/1ns
`include "nvac_defs.vh"
module nvac_key_seq (
	// Clock and reset
	input wire clk_sys_i,
	input wire rst_b_i,
	input wire soft_rst_i,
	// Key port writes
	input wire key_we_i,
	input wire [7:0] key_d_i,
	// Store start consumes the unlock
	input wire consume_i,
	output wire armed_o
);

	reg first_q;
	reg armed_q;

	assign armed_o = armed_q;

	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			first_q <= 1'b0;
			armed_q <= 1'b0;
		end else if (soft_rst_i || consume_i) begin
			first_q <= 1'b0;
			armed_q <= 1'b0;
		end else if (key_we_i) begin
			// Any out-of-order key write drops the sequence
			first_q <= (key_d_i == `NVAC_KEY_FIRST);
			armed_q <= first_q && (key_d_i == `NVAC_KEY_SECOND);
		end
	end

endmodule

// ---- bench/nvac_top_checker.sv ----
`timescale 1ns/1ns
module nvac_top_checker (
	// Watched ports
	input wire clk_sys_i,
	input wire rst_b_i,
	input wire external_reset_pin_i,
	input wire watchdog_expiry_i,
	input wire [2:0] sfr_sel_i,
	input wire sfr_we_i,
	input wire sfr_re_i,
	input wire [7:0] sfr_wdata_i,
	input wire [7:0] sfr_rdata_o,
	input wire store_done_flag_clr_i,
	input wire store_done_irq_flag_o,
	input wire mem_space_o,
	input wire [12:0] mem_addr_o,
	input wire mem_erase_req_o,
	input wire mem_prog_req_o,
	input wire mem_op_done_i
);
	// Reads on warm-reset edges are ignored, so only clean reads count
	wire rd_ok = sfr_re_i && !external_reset_pin_i && !watchdog_expiry_i;
	// Permit as last written, so that a store start can be traced to it
	reg permit_seen = 1'b0;
	always @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			permit_seen <= 1'b0;
		end else if (external_reset_pin_i || watchdog_expiry_i) begin
			permit_seen <= 1'b0;
		end else if (sfr_we_i && sfr_sel_i == 3'h0) begin
			permit_seen <= sfr_wdata_i[2];
		end
	end
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	a_key_zero: assert property (rd_ok && sfr_sel_i == 3'h1 |=> sfr_rdata_o == 8'h00)
		else $error("key port read nonzero");
	a_data_hi_top: assert property (rd_ok && sfr_sel_i == 3'h3 |=> sfr_rdata_o[7:6] == 2'h0)
		else $error("data high top bits set");
	a_prog_no_store: assert property (mem_space_o |-> !mem_erase_req_o && !mem_prog_req_o)
		else $error("store in program space");
	a_data_addr_byte: assert property (!mem_space_o |-> mem_addr_o[12:8] == 5'h00)
		else $error("data address above byte");
	a_store_cause: assert property (mem_erase_req_o |-> $past(sfr_we_i && sfr_sel_i == 3'h0 && sfr_wdata_i[1] &&
		!sfr_wdata_i[0] && !sfr_wdata_i[7] && permit_seen))
		else $error("erase without permitted trigger");
	a_prog_after_done: assert property (mem_prog_req_o |-> $past(mem_op_done_i))
		else $error("program without erase done");
	a_flag_sticky: assert property (store_done_irq_flag_o && !store_done_flag_clr_i |=> store_done_irq_flag_o)
		else $error("done flag dropped");
	a_warm_space: assert property (external_reset_pin_i || watchdog_expiry_i |=> !mem_space_o)
		else $error("space kept over warm reset");
endmodule
bind nvac_top nvac_top_checker chk_u (
	.clk_sys_i(clk_sys_i),
	.rst_b_i(rst_b_i),
	.external_reset_pin_i(external_reset_pin_i),
	.watchdog_expiry_i(watchdog_expiry_i),
	.sfr_sel_i(sfr_sel_i),
	.sfr_we_i(sfr_we_i),
	.sfr_re_i(sfr_re_i),
	.sfr_wdata_i(sfr_wdata_i),
	.sfr_rdata_o(sfr_rdata_o),
	.store_done_flag_clr_i(store_done_flag_clr_i),
	.store_done_irq_flag_o(store_done_irq_flag_o),
	.mem_space_o(mem_space_o),
	.mem_addr_o(mem_addr_o),
	.mem_erase_req_o(mem_erase_req_o),
	.mem_prog_req_o(mem_prog_req_o),
	.mem_op_done_i(mem_op_done_i)
);

// ---- bench/nvac_array_model.sv ----
`timescale 1ns/1ns
module nvac_array_model #(
	parameter [3:0] DLY = 4'h5
) (
	// Clock
	input wire clk_sys_i,
	// Requests
	input wire mem_space_i,
	input wire [12:0] mem_addr_i,
	input wire [7:0] mem_wdata_i,
	input wire mem_rd_req_i,
	input wire mem_erase_req_i,
	input wire mem_prog_req_i,
	// Answers
	output reg [13:0] mem_rdata_o = 14'h0,
	output reg mem_op_done_o = 1'b0
);
	reg [7:0] mem_q [0:255];
	reg [3:0] cnt_q = 4'h0;
	reg prog_q = 1'b0;
	integer i;
	initial begin
		for (i = 0; i < 256; i = i + 1) begin
			mem_q[i] = i[7:0] ^ 8'h96;
		end
	end
	always @(posedge clk_sys_i) begin
		mem_op_done_o <= 1'b0;
		// Idle read lines toggle so stale data never passes for fresh
		if (mem_rd_req_i) begin
			mem_rdata_o <= mem_space_i ? {mem_addr_i[12:7] ^ 6'h2a, mem_addr_i[7:0] ^ 8'h5c} : {6'h00, mem_q[mem_addr_i[7:0]]};
		end else begin
			mem_rdata_o <= ~mem_rdata_o;
		end
		if (mem_erase_req_i || mem_prog_req_i) begin
			cnt_q <= DLY;
			prog_q <= mem_prog_req_i;
		end else if (cnt_q != 4'h0) begin
			cnt_q <= cnt_q - 4'h1;
			if (cnt_q == 4'h1) begin
				mem_op_done_o <= 1'b1;
				mem_q[mem_addr_i[7:0]] <= prog_q ? mem_wdata_i : 8'hff;
			end
		end
	end
endmodule

// ---- bench/nvac_top_bench.sv ----
`timescale 1ns/1ns
module nvac_top_bench;
	reg clk_sys_i = 1'b0;
	reg rst_b_i = 1'b0;
	reg ext = 1'b0;
	reg wdg = 1'b0;
	reg we = 1'b0;
	reg re = 1'b0;
	reg clr = 1'b0;
	reg [2:0] sel = 3'h0;
	reg [7:0] wdata = 8'h00;
	wire [7:0] rdata;
	wire [7:0] mwd;
	wire [12:0] addr;
	wire [13:0] mrd;
	wire flag, sp, rq, eq, pq, done;
	integer failures = 0;
	integer samples_checked = 0;
	integer k;
	always #5 clk_sys_i = ~clk_sys_i;
	nvac_top dut_u (
		.clk_sys_i(clk_sys_i),
		.rst_b_i(rst_b_i),
		.external_reset_pin_i(ext),
		.watchdog_expiry_i(wdg),
		.sfr_sel_i(sel),
		.sfr_we_i(we),
		.sfr_re_i(re),
		.sfr_wdata_i(wdata),
		.sfr_rdata_o(rdata),
		.store_done_flag_clr_i(clr),
		.store_done_irq_flag_o(flag),
		.mem_space_o(sp),
		.mem_addr_o(addr),
		.mem_wdata_o(mwd),
		.mem_rd_req_o(rq),
		.mem_erase_req_o(eq),
		.mem_prog_req_o(pq),
		.mem_rdata_i(mrd),
		.mem_op_done_i(done)
	);
	nvac_array_model mdl_u (
		.clk_sys_i(clk_sys_i),
		.mem_space_i(sp),
		.mem_addr_i(addr),
		.mem_wdata_i(mwd),
		.mem_rd_req_i(rq),
		.mem_erase_req_i(eq),
		.mem_prog_req_i(pq),
		.mem_rdata_o(mrd),
		.mem_op_done_o(done)
	);
	task finish_test;
		begin
			$display("failures %0d samples_checked %0d", failures, samples_checked);
			if (failures == 0 && samples_checked > 0) begin
				$display("verification passed");
			end else begin
				$display("verification failed");
			end
			$finish;
		end
	endtask
	task chk(input [7:0] g, input [7:0] e);
		begin
			samples_checked = samples_checked + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("mismatch %0t got %h exp %h", $time, g, e);
			end
		end
	endtask
	task wr(input [2:0] s, input [7:0] d);
		begin
			@(posedge clk_sys_i);
			sel <= s;
			wdata <= d;
			we <= 1'b1;
			@(posedge clk_sys_i);
			we <= 1'b0;
		end
	endtask
	task rdv(input [2:0] s);
		begin
			@(posedge clk_sys_i);
			sel <= s;
			re <= 1'b1;
			@(posedge clk_sys_i);
			re <= 1'b0;
			@(negedge clk_sys_i);
		end
	endtask
	task rd(input [2:0] s, input [7:0] e);
		begin
			rdv(s);
			chk(rdata, e);
		end
	endtask
	task unlock;
		begin
			wr(3'h1, 8'h55);
			wr(3'h1, 8'haa);
		end
	endtask
	// Polls control until the masked trigger clears, bounded
	task wait_idle(input [7:0] m);
		integer n;
		begin
			rdv(3'h0);
			for (n = 0; n < 40 && (rdata & m) !== 8'h00; n = n + 1) begin
				rdv(3'h0);
			end
			if ((rdata & m) !== 8'h00) begin
				failures = failures + 1;
				finish_test;
			end
		end
	endtask
	initial begin
		repeat (16) @(posedge clk_sys_i);
		rst_b_i <= 1'b1;
		for (k = 0; k < 8; k = k + 1) begin
			rd(k[2:0], 8'h00);
		end
		wr(3'h2, 8'ha5);
		rd(3'h2, 8'ha5);
		wr(3'h3, 8'hff);
		rd(3'h3, 8'h3f);
		wr(3'h5, 8'hff);
		rd(3'h5, 8'h1f);
		wr(3'h1, 8'h77);
		rd(3'h1, 8'h00);
		wr(3'h4, 8'h3c);
		rd(3'h4, 8'h3c);
		wr(3'h0, 8'h01);
		wait_idle(8'h01);
		rd(3'h2, 8'haa);
		wr(3'h5, 8'h12);
		wr(3'h4, 8'h34);
		wr(3'h0, 8'h81);
		wait_idle(8'h01);
		rd(3'h2, 8'h68);
		rd(3'h3, 8'h0e);
		wr(3'h0, 8'h04);
		unlock;
		wr(3'h0, 8'h86);
		rd(3'h0, 8'h84);
		wr(3'h0, 8'h00);
		unlock;
		wr(3'h0, 8'h02);
		rd(3'h0, 8'h00);
		wr(3'h0, 8'h04);
		wr(3'h1, 8'h55);
		wr(3'h1, 8'h56);
		wr(3'h0, 8'h06);
		rd(3'h0, 8'h04);
		wr(3'h4, 8'h10);
		wr(3'h2, 8'h5e);
		unlock;
		wr(3'h0, 8'h06);
		wr(3'h0, 8'h04);
		rd(3'h0, 8'h06);
		wait_idle(8'h02);
		chk({7'h0, flag}, 8'h01);
		wr(3'h2, 8'h00);
		wr(3'h0, 8'h01);
		wait_idle(8'h01);
		rd(3'h2, 8'h5e);
		chk({7'h0, flag}, 8'h01);
		@(posedge clk_sys_i);
		clr <= 1'b1;
		@(posedge clk_sys_i);
		clr <= 1'b0;
		@(negedge clk_sys_i);
		chk({7'h0, flag}, 8'h00);
		for (k = 0; k < 2; k = k + 1) begin
			wr(3'h0, 8'h04);
			unlock;
			wr(3'h0, 8'h06);
			@(posedge clk_sys_i);
			ext <= (k == 0);
			wdg <= (k == 1);
			@(posedge clk_sys_i);
			ext <= 1'b0;
			wdg <= 1'b0;
			rd(3'h0, 8'h08);
			wr(3'h0, 8'h00);
		end
		finish_test;
	end
endmodule
